// ### hw/sccr_defines.vh
// Purpose: constants for the sync, coast and configuration register bank
// Assumes: byte-wide register port, 8-bit registers
// Notes:   offsets are the register indices of the serial control map
`ifndef SCCR_DEFINES_VH
`define SCCR_DEFINES_VH

// ---------------------------------------------------------------------------
// register offsets
// ---------------------------------------------------------------------------
`define SCCR_ADDR_SRC_PWR     8'h12
`define SCCR_ADDR_SEP_THRESH  8'h13
`define SCCR_ADDR_SCAN_POL    8'h14
`define SCCR_ADDR_POL_STATUS  8'h15
`define SCCR_ADDR_SLICER      8'h16
`define SCCR_ADDR_PRECOAST    8'h17
`define SCCR_ADDR_POSTCOAST   8'h18
`define SCCR_ADDR_TEST_A      8'h19
`define SCCR_ADDR_TEST_B      8'h1A
`define SCCR_ADDR_GAIN_MODE   8'h1B
`define SCCR_ADDR_OUT_FMT     8'h1C

// ---------------------------------------------------------------------------
// reset values
// ---------------------------------------------------------------------------
`define SCCR_RST_SRC_PWR      8'h01
`define SCCR_RST_SEP_THRESH   8'h20
`define SCCR_RST_SCAN_POL     8'h10
`define SCCR_RST_SLICER       6'h2F
`define SCCR_RST_PRECOAST     8'h00
`define SCCR_RST_POSTCOAST    8'h00
`define SCCR_RST_TEST_A       8'h00
`define SCCR_RST_TEST_B       8'hFF
`define SCCR_RST_GAIN_MODE    8'h00
`define SCCR_RST_OUT_FMT      8'h07

// ---------------------------------------------------------------------------
// field positions
// ---------------------------------------------------------------------------
`define SCCR_BIT_VS_OVERRIDE  3
`define SCCR_BIT_VS_SELECT    2
`define SCCR_BIT_COAST_SRC    1
`define SCCR_BIT_SLEEP_N      0
`define SCCR_BIT_SCAN_EN      2
`define SCCR_BIT_COAST_POL_OV 1
`define SCCR_BIT_HS_POL_OV    0
`define SCCR_BIT_CBCR_ORDER   2
`define SCCR_BIT_FMT_444      0

`endif

// ### hw/sccr_sync_sep.v
// Purpose: sync separator, extracts vertical sync from composite sync
// Assumes: composite sync already normalised to active high
// Notes:   output follows input only after it has held for thresh+1 cycles
`timescale 1ns/10ps

module sccr_sync_sep #(
  parameter CNT_W = 8
) (
  input  wire             i_clk_sys,  // system clock
  input  wire             i_rst_n,    // synchronised reset, active low
  input  wire             i_enable,   // low holds separator idle
  input  wire [CNT_W-1:0] i_thresh,   // cycle count threshold
  input  wire             i_csync,    // composite sync, active high
  output reg              o_sep       // separated vertical sync
);

  reg [CNT_W-1:0] cnt_reg;

  // ---------------------------------------------------------------------------
  // width counter
  // ---------------------------------------------------------------------------
  // short pulses (hsync, equalisation) never reach the threshold
  always @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_reg <= {CNT_W{1'b0}};
      o_sep   <= 1'b0;
    end else if (!i_enable) begin
      cnt_reg <= {CNT_W{1'b0}};
      o_sep   <= 1'b0;
    end else if (i_csync == o_sep) begin
      cnt_reg <= {CNT_W{1'b0}};
    end else if (cnt_reg >= i_thresh) begin
      cnt_reg <= {CNT_W{1'b0}};
      o_sep   <= i_csync;
    end else begin
      cnt_reg <= cnt_reg + 1'b1;
    end
  end

endmodule

// ### hw/sccr_top.v
// Purpose: sync source, coast and configuration register bank
// Assumes: register port is the decoded side of the serial control link
// Notes:   all sync inputs synchronous to i_clk_sys
`timescale 1ns/10ps
`include "sccr_defines.vh"

module sccr_top #(
  parameter LINE_W = 12
) (
  input  wire       i_clk_sys,        // system clock, 100 MHz
  input  wire       i_reset_n,        // asynchronous reset, active low
  input  wire [7:0] i_reg_addr,       // register index
  input  wire [7:0] i_reg_wdata,      // write data
  input  wire       i_reg_wr,         // write strobe, one cycle
  input  wire       i_reg_rd,         // read strobe, one cycle
  output reg  [7:0] o_reg_rdata,      // read data, valid cycle after strobe
  input  wire       i_hsync,          // hsync input, raw polarity
  input  wire       i_vsync_raw,      // unprocessed vsync, active high
  input  wire       i_csync,          // composite sync, active high
  input  wire       i_coast_pin,      // coast pin, raw polarity
  input  wire       i_hs_pol_det,     // detected hsync polarity, 1 = high
  input  wire       i_coast_pol_det,  // detected coast polarity, 1 = high
  input  wire       i_user_hs_pol,    // user hsync polarity
  input  wire       i_user_coast_pol, // user coast polarity
  input  wire       i_vs_auto_sel,    // auto vsync choice, 1 = separator
  input  wire       i_vs_out_act_low, // vsync output is active low
  output reg        o_chip_sleep_n,   // full chip power-down, active low
  output reg        o_scan_en,        // scan function enable
  output reg        o_hs_pol,         // effective hsync polarity
  output reg        o_coast_pol,      // effective coast polarity
  output reg  [4:0] o_sog_thresh,     // sync-on-green slicer threshold
  output reg        o_fmt_444,        // 1 = 4:4:4, 0 = 4:2:2
  output reg        o_cbcr_order,     // chroma output order
  output reg        o_vsync,          // selected vsync
  output reg        o_pll_hold        // pll hold (coast), active high
);

  // ---------------------------------------------------------------------------
  // reset release
  // ---------------------------------------------------------------------------
  reg  [1:0] rst_sync_reg;
  wire       rst_n;

  always @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rst_sync_reg <= 2'b00;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end

  assign rst_n = rst_sync_reg[1];

  // ---------------------------------------------------------------------------
  // register storage
  // ---------------------------------------------------------------------------
  reg  [7:0] src_pwr_reg;
  reg  [7:0] sep_thresh_reg;
  reg  [7:0] scan_pol_reg;
  reg  [7:0] pol_status_reg;
  reg  [5:0] slicer_reg;
  reg  [7:0] precoast_reg;
  reg  [7:0] postcoast_reg;
  reg  [7:0] test_a_reg;
  reg  [7:0] test_b_reg;
  reg  [7:0] gain_mode_reg;
  reg  [7:0] out_fmt_reg;

  // fixed-value fields are stored as written, except slicer bits 1:0, which are dropped; software owns them
  always @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      src_pwr_reg    <= `SCCR_RST_SRC_PWR;
      sep_thresh_reg <= `SCCR_RST_SEP_THRESH;
      scan_pol_reg   <= `SCCR_RST_SCAN_POL;
      slicer_reg     <= `SCCR_RST_SLICER;
      precoast_reg   <= `SCCR_RST_PRECOAST;
      postcoast_reg  <= `SCCR_RST_POSTCOAST;
      test_a_reg     <= `SCCR_RST_TEST_A;
      test_b_reg     <= `SCCR_RST_TEST_B;
      gain_mode_reg  <= `SCCR_RST_GAIN_MODE;
      out_fmt_reg    <= `SCCR_RST_OUT_FMT;
    end else if (i_reg_wr) begin
      case (i_reg_addr)
        `SCCR_ADDR_SRC_PWR:    src_pwr_reg    <= i_reg_wdata;
        `SCCR_ADDR_SEP_THRESH: sep_thresh_reg <= i_reg_wdata;
        `SCCR_ADDR_SCAN_POL:   scan_pol_reg   <= i_reg_wdata;
        `SCCR_ADDR_SLICER:     slicer_reg     <= i_reg_wdata[7:2];
        `SCCR_ADDR_PRECOAST:   precoast_reg   <= i_reg_wdata;
        `SCCR_ADDR_POSTCOAST:  postcoast_reg  <= i_reg_wdata;
        `SCCR_ADDR_TEST_A:     test_a_reg     <= i_reg_wdata;
        `SCCR_ADDR_TEST_B:     test_b_reg     <= i_reg_wdata;
        `SCCR_ADDR_GAIN_MODE:  gain_mode_reg  <= i_reg_wdata;
        `SCCR_ADDR_OUT_FMT:    out_fmt_reg    <= i_reg_wdata;
        default: begin
        end
      endcase
    end
  end

  // ---------------------------------------------------------------------------
  // read port
  // ---------------------------------------------------------------------------
  reg [7:0] rdata_next;

  // unmapped indices and status low bits read as zero
  always @* begin
    case (i_reg_addr)
      `SCCR_ADDR_SRC_PWR:    rdata_next = src_pwr_reg;
      `SCCR_ADDR_SEP_THRESH: rdata_next = sep_thresh_reg;
      `SCCR_ADDR_SCAN_POL:   rdata_next = scan_pol_reg;
      `SCCR_ADDR_POL_STATUS: rdata_next = pol_status_reg;
      `SCCR_ADDR_SLICER:     rdata_next = {slicer_reg, 2'b00};
      `SCCR_ADDR_PRECOAST:   rdata_next = precoast_reg;
      `SCCR_ADDR_POSTCOAST:  rdata_next = postcoast_reg;
      `SCCR_ADDR_TEST_A:     rdata_next = test_a_reg;
      `SCCR_ADDR_TEST_B:     rdata_next = test_b_reg;
      `SCCR_ADDR_GAIN_MODE:  rdata_next = gain_mode_reg;
      `SCCR_ADDR_OUT_FMT:    rdata_next = out_fmt_reg;
      default:               rdata_next = 8'h00;
    endcase
  end

  always @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      o_reg_rdata <= 8'h00;
    end else if (i_reg_rd) begin
      o_reg_rdata <= rdata_next;
    end
  end

  // ---------------------------------------------------------------------------
  // control decode
  // ---------------------------------------------------------------------------
  wire awake;
  wire vs_use_sep;
  wire hs_pol_next;
  wire coast_pol_next;

  assign awake = src_pwr_reg[`SCCR_BIT_SLEEP_N];

  // user choice only counts while override is set
  assign vs_use_sep = src_pwr_reg[`SCCR_BIT_VS_OVERRIDE] ?
                      src_pwr_reg[`SCCR_BIT_VS_SELECT] :
                      i_vs_auto_sel;

  assign hs_pol_next = scan_pol_reg[`SCCR_BIT_HS_POL_OV] ?
                       i_user_hs_pol : i_hs_pol_det;

  assign coast_pol_next = scan_pol_reg[`SCCR_BIT_COAST_POL_OV] ?
                          i_user_coast_pol : i_coast_pol_det;

  always @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      o_chip_sleep_n <= 1'b1;
      o_scan_en      <= 1'b0;
      o_hs_pol       <= 1'b0;
      o_coast_pol    <= 1'b0;
      o_sog_thresh   <= 5'h17;
      o_fmt_444      <= 1'b1;
      o_cbcr_order   <= 1'b1;
      pol_status_reg <= 8'h00;
    end else begin
      o_chip_sleep_n <= awake;
      o_scan_en      <= scan_pol_reg[`SCCR_BIT_SCAN_EN];
      o_hs_pol       <= hs_pol_next;
      o_coast_pol    <= coast_pol_next;
      o_sog_thresh   <= slicer_reg[5:1];
      o_fmt_444      <= out_fmt_reg[`SCCR_BIT_FMT_444];
      o_cbcr_order   <= out_fmt_reg[`SCCR_BIT_CBCR_ORDER];
      pol_status_reg <= {i_hs_pol_det,
                         i_vs_out_act_low,
                         i_coast_pol_det,
                         5'h00};
    end
  end

  // ---------------------------------------------------------------------------
  // vsync path
  // ---------------------------------------------------------------------------
  wire sep_vsync;

  sccr_sync_sep #(
    .CNT_W (8)
  ) u_sync_sep (
    .i_clk_sys (i_clk_sys),
    .i_rst_n   (rst_n),
    .i_enable  (awake),
    .i_thresh  (sep_thresh_reg),
    .i_csync   (i_csync),
    .o_sep     (sep_vsync)
  );

  always @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      o_vsync <= 1'b0;
    end else begin
      o_vsync <= awake & (vs_use_sep ? sep_vsync : i_vsync_raw);
    end
  end

  // ---------------------------------------------------------------------------
  // coast generation
  // ---------------------------------------------------------------------------
  reg  [LINE_W-1:0] line_cnt_reg;
  reg  [LINE_W-1:0] frame_len_reg;
  reg               frame_ok_reg;
  reg  [7:0]        post_cnt_reg;
  reg               hs_act_d_reg;
  reg               vs_d_reg;
  wire              hs_act;
  wire              hs_edge;
  wire              vs_edge;
  wire              coast_pin_act;
  wire [LINE_W:0]   line_plus_pre;
  wire              pre_act;
  wire              post_act;
  wire              hold_next;

  assign hs_act        = o_hs_pol ? i_hsync : ~i_hsync;
  assign coast_pin_act = o_coast_pol ? i_coast_pin : ~i_coast_pin;
  assign hs_edge       = hs_act & ~hs_act_d_reg;
  assign vs_edge       = o_vsync & ~vs_d_reg;
  assign line_plus_pre = {1'b0, line_cnt_reg} + {{(LINE_W-7){1'b0}}, precoast_reg};

  // lines per frame learnt from the previous frame
  always @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      hs_act_d_reg  <= 1'b0;
      vs_d_reg      <= 1'b0;
      line_cnt_reg  <= {LINE_W{1'b0}};
      frame_len_reg <= {LINE_W{1'b0}};
      frame_ok_reg  <= 1'b0;
      post_cnt_reg  <= 8'h00;
    end else begin
      hs_act_d_reg <= hs_act;
      vs_d_reg     <= o_vsync;
      if (vs_edge) begin
        line_cnt_reg  <= {LINE_W{1'b0}};
        frame_len_reg <= line_cnt_reg;
        frame_ok_reg  <= 1'b1;
        post_cnt_reg  <= postcoast_reg;
      end else begin
        if (hs_edge && line_cnt_reg != {LINE_W{1'b1}}) begin
          line_cnt_reg <= line_cnt_reg + 1'b1;
        end
        if (hs_edge && !o_vsync && post_cnt_reg != 8'h00) begin
          post_cnt_reg <= post_cnt_reg - 8'h01;
        end
      end
    end
  end

  assign pre_act = frame_ok_reg && (precoast_reg != 8'h00) &&
                   (line_plus_pre >= {1'b0, frame_len_reg});
  assign post_act = o_vsync || (post_cnt_reg != 8'h00);

  assign hold_next = src_pwr_reg[`SCCR_BIT_COAST_SRC] ?
                     (pre_act | post_act) : coast_pin_act;

  // pll keeps its frequency while hold is high
  always @(posedge i_clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      o_pll_hold <= 1'b0;
    end else begin
      o_pll_hold <= awake & hold_next;
    end
  end

endmodule

// ### verif/sccr_checker.sv
// Purpose: port-level checks of the sync, coast and config bank
// Assumes: shadows of 0x12 and 0x14 track writes the way the bank stores them
// Notes:   checks idle until a 4-stage shift of their own has let go, two cycles after the bank's reset synchroniser
`timescale 1ns/10ps
module sccr_checker #(
  parameter LINE_W = 12
) (
  input wire       i_clk_sys, i_reset_n, i_reg_wr, i_reg_rd,
  input wire [7:0] i_reg_addr, i_reg_wdata, o_reg_rdata,
  input wire       i_vsync_raw, i_coast_pin, i_hs_pol_det, i_coast_pol_det,
  input wire       i_user_hs_pol, i_user_coast_pol, i_vs_auto_sel, i_vs_out_act_low,
  input wire       o_chip_sleep_n, o_scan_en, o_hs_pol, o_coast_pol,
  input wire [4:0] o_sog_thresh,
  input wire       o_fmt_444, o_cbcr_order, o_vsync, o_pll_hold
);
  reg  [3:0] rst_q;
  reg  [7:0] src_reg;
  reg  [7:0] pol_reg;
  wire       vs_sel = src_reg[3] ? src_reg[2] : i_vs_auto_sel;
  wire       wr_src = i_reg_wr && (i_reg_addr == 8'h12);
  wire       wr_pol = i_reg_wr && (i_reg_addr == 8'h14);
  wire       wr_slc = i_reg_wr && (i_reg_addr == 8'h16);
  wire       wr_fmt = i_reg_wr && (i_reg_addr == 8'h1C);
  wire       wr_pre = i_reg_wr && (i_reg_addr == 8'h17);
  always @(posedge i_clk_sys or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rst_q   <= 4'h0;
      src_reg <= 8'h01;
      pol_reg <= 8'h10;
    end else begin
      rst_q <= {rst_q[2:0], 1'b1};
      if (wr_src) src_reg <= i_reg_wdata;
      if (wr_pol) pol_reg <= i_reg_wdata;
    end
  end
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!rst_q[3]);
  a_sleep_follow: assert property (wr_src ##1 !wr_src |=> o_chip_sleep_n == $past(i_reg_wdata[0], 2))
    else $error("power-down output differs from written bit");
  a_scan_follow: assert property (wr_pol ##1 !wr_pol |=> o_scan_en == $past(i_reg_wdata[2], 2))
    else $error("scan enable differs from written bit");
  a_slicer_follow: assert property (wr_slc ##1 !wr_slc |=> o_sog_thresh == $past(i_reg_wdata[7:3], 2))
    else $error("slicer threshold differs from written field");
  a_format_follow: assert property (wr_fmt ##1 !wr_fmt |=> o_fmt_444 == $past(i_reg_wdata[0], 2) && o_cbcr_order == $past(i_reg_wdata[2], 2))
    else $error("format outputs differ from written bits");
  a_precoast_back: assert property (wr_pre ##1 (i_reg_rd && !i_reg_wr && i_reg_addr == 8'h17) |=> o_reg_rdata == $past(i_reg_wdata, 2))
    else $error("precoast read differs from last write");
  a_status_read: assert property (i_reg_rd && i_reg_addr == 8'h15 |=> o_reg_rdata == {$past(i_hs_pol_det, 2), $past(i_vs_out_act_low, 2), $past(i_coast_pol_det, 2), 5'h00})
    else $error("polarity status read wrong");
  a_hs_polarity: assert property (o_hs_pol == ($past(pol_reg[0]) ? $past(i_user_hs_pol) : $past(i_hs_pol_det)))
    else $error("hsync polarity source wrong");
  a_coast_polarity: assert property (o_coast_pol == ($past(pol_reg[1]) ? $past(i_user_coast_pol) : $past(i_coast_pol_det)))
    else $error("coast polarity source wrong");
  a_vsync_raw: assert property ($past(src_reg[0]) && !$past(vs_sel) |-> o_vsync == $past(i_vsync_raw))
    else $error("raw vsync not passed through");
  a_sleep_gate: assert property (!$past(src_reg[0]) |-> !o_vsync && !o_pll_hold)
    else $error("vsync or hold active in power-down");
  a_hold_pin: assert property ($past(src_reg[0]) && !$past(src_reg[1]) |-> o_pll_hold == ($past(i_coast_pin) ~^ $past(o_coast_pol)))
    else $error("hold does not follow coast pin");
  a_hold_vsync: assert property (o_vsync && src_reg[1:0] == 2'b11 |=> o_pll_hold)
    else $error("hold not raised by vsync");
  c_sleep_write: cover property (wr_src ##1 !wr_src);
  c_status_read: cover property (i_reg_rd && i_reg_addr == 8'h15);
  c_vsync_hold: cover property (o_vsync && src_reg[1:0] == 2'b11);
endmodule
bind sccr_top sccr_checker #(.LINE_W(LINE_W)) chk (
  .i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
  .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata),
  .i_vsync_raw(i_vsync_raw), .i_coast_pin(i_coast_pin), .i_hs_pol_det(i_hs_pol_det),
  .i_coast_pol_det(i_coast_pol_det), .i_user_hs_pol(i_user_hs_pol),
  .i_user_coast_pol(i_user_coast_pol), .i_vs_auto_sel(i_vs_auto_sel),
  .i_vs_out_act_low(i_vs_out_act_low), .o_chip_sleep_n(o_chip_sleep_n), .o_scan_en(o_scan_en),
  .o_hs_pol(o_hs_pol), .o_coast_pol(o_coast_pol), .o_sog_thresh(o_sog_thresh),
  .o_fmt_444(o_fmt_444), .o_cbcr_order(o_cbcr_order), .o_vsync(o_vsync), .o_pll_hold(o_pll_hold)
);

// ### verif/tb.sv
// Purpose: self-checking bench for the sync, coast and config bank
// Assumes: byte register port, read data one cycle after the strobe
// Notes:   model mirrors stored bytes; status comes from the polarity inputs
`timescale 1ns/10ps
module tb;
  reg         clk, rst_n, wr, rd, vsr, cs, cpin, hdet, cdet, uhs, uco, vlow;
  reg  [7:0]  addr, wdata, q, a;
  wire [7:0]  rdata;
  wire [4:0]  sog;
  wire        sleep_n, scan, hpol, cpol, fmt, cbcr, vs, hold;
  reg  [31:0] seed;
  reg  [7:0]  mdl [0:255];
  reg  [95:0] cfg;
  reg         pv, pp, pc, pvo;
  integer     err_total, n_tests, i, k, th;
  sccr_top dut (
    .i_clk_sys(clk), .i_reset_n(rst_n), .i_reg_addr(addr), .i_reg_wdata(wdata),
    .i_reg_wr(wr), .i_reg_rd(rd), .o_reg_rdata(rdata), .i_hsync(1'b0), .i_vsync_raw(vsr),
    .i_csync(cs), .i_coast_pin(cpin), .i_hs_pol_det(hdet), .i_coast_pol_det(cdet),
    .i_user_hs_pol(uhs), .i_user_coast_pol(uco), .i_vs_auto_sel(1'b0),
    .i_vs_out_act_low(vlow), .o_chip_sleep_n(sleep_n), .o_scan_en(scan), .o_hs_pol(hpol),
    .o_coast_pol(cpol), .o_sog_thresh(sog), .o_fmt_444(fmt), .o_cbcr_order(cbcr),
    .o_vsync(vs), .o_pll_hold(hold)
  );
  function [7:0] exp_rd(input [7:0] ad);
    exp_rd = (ad == 8'h15) ? {hdet, vlow, cdet, 5'h00} : mdl[ad];
  endfunction
  task rnd;
    begin
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
    end
  endtask
  task chk(input [8*12-1:0] nm, input [7:0] seen, input [7:0] exp);
    begin
      n_tests = n_tests + 1;
      if (seen !== exp) begin
        err_total = err_total + 1;
        $display("unexpected %0s: expected %h seen %h", nm, exp, seen);
      end
    end
  endtask
  task acc(input w, input r, input [7:0] ad, input [7:0] dt);
    begin
      @(posedge clk);
      #1;
      {wr, rd, addr, wdata} = {w, r, ad, dt};
      @(posedge clk);
      #1;
      {wr, rd} = 2'b00;
      q = rdata;
    end
  endtask
  task wrm(input [7:0] ad, input [7:0] dt);
    begin
      acc(1'b1, 1'b0, ad, dt);
      if (ad >= 8'h12 && ad <= 8'h1C && ad != 8'h15)
        mdl[ad] = (ad == 8'h16) ? (dt & 8'hFC) : dt;
    end
  endtask
  task complete_run;
    begin
      $display("comparisons %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0)
        $display("[ PASS ]");
      else
        $display("[ FAIL ]");
      $finish;
    end
  endtask
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    #200000;
    err_total = err_total + 1;
    complete_run;
  end
  initial begin
    {wr, rd, vsr, cs, cpin, hdet, cdet, uhs, uco, vlow} = 10'h000;
    {addr, wdata, rst_n, seed, err_total, n_tests} = {16'h0000, 1'b0, 32'h4167, 64'h0};
    for (i = 0; i < 256; i = i + 1) mdl[i] = 8'h00;
    {mdl[8'h12], mdl[8'h13], mdl[8'h14], mdl[8'h16]} = 32'h012010BC;
    {mdl[8'h1A], mdl[8'h1C]} = 16'hFF07;
    repeat (6) @(posedge clk);
    #1 rst_n = 1'b1;
    repeat (3) @(posedge clk);
    for (i = 8'h11; i <= 8'h1D; i = i + 1) begin
      acc(1'b0, 1'b1, i[7:0], 8'h00);
      chk("reset value", q, exp_rd(i[7:0]));
    end
    chk("reset sog", sog, 8'h17);
    chk("reset outs", {sleep_n, scan, fmt}, 8'h05);
    $display("test reset done");
    for (k = 0; k < 40; k = k + 1) begin
      rnd;
      {hdet, cdet, uhs, uco, vlow} = seed[4:0];
      a = seed[8] ? seed[7:0] : 8'h12 + seed[7:0] % 11;
      rnd;
      wrm(a, seed[7:0]);
      acc(1'b0, 1'b1, a, 8'h00);
      chk("readback", q, exp_rd(a));
      acc(1'b0, 1'b1, 8'h15, 8'h00);
      chk("status", q, exp_rd(8'h15));
      chk("sleep", sleep_n, mdl[8'h12][0]);
      chk("scan", scan, mdl[8'h14][2]);
      chk("sog", sog, mdl[8'h16][7:3]);
      chk("format", {cbcr, fmt}, {mdl[8'h1C][2], mdl[8'h1C][0]});
      chk("hs pol", hpol, mdl[8'h14][0] ? uhs : hdet);
      chk("coast pol", cpol, mdl[8'h14][1] ? uco : cdet);
    end
    acc(1'b1, 1'b1, 8'h17, 8'h5A);
    chk("wr rd same", q, mdl[8'h17]);
    mdl[8'h17] = 8'h5A;
    acc(1'b0, 1'b1, 8'h17, 8'h00);
    chk("precoast", q, 8'h5A);
    $display("test registers done");
    cfg = 96'h1410_16B8_1900_1A41_1B10_1C29;
    for (i = 0; i < 6; i = i + 1) wrm(cfg[95-16*i -: 8], cfg[87-16*i -: 8]);
    for (i = 0; i < 4; i = i + 1) begin
      wrm(8'h12, 8'(32'h09010B08 >> (24 - 8 * i)));
      for (k = 0; k < 30; k = k + 1) begin
        @(posedge clk);
        #1;
        if (k > 1) begin
          chk("vsync", vs, mdl[8'h12][0] & pv);
          if (!mdl[8'h12][1]) chk("hold pin", hold, mdl[8'h12][0] & (pp ~^ pc));
          else if (pvo) chk("hold vsync", hold, 1'b1);
        end
        rnd;
        {vsr, cpin} = seed[1:0];
        {pv, pp, pc, pvo} = {vsr, cpin, cpol, vs};
      end
    end
    $display("test sync path done");
    wrm(8'h12, 8'h0D);
    for (i = 0; i < 2; i = i + 1) begin
      rnd;
      th = (i == 0) ? 3 : 2 + seed[2:0];
      wrm(8'h13, th[7:0]);
      repeat (20) @(posedge clk);
      #1 cs = 1'b1;
      for (k = 0; k < th + 6; k = k + 1) begin
        @(posedge clk);
        #1;
        if (k == th - 2) cs = 1'b0;
        chk("glitch", vs, 1'b0);
      end
      cs = 1'b1;
      for (k = 0; k < th + 6; k = k + 1) begin
        @(posedge clk);
        #1;
        if (k < th) chk("sep early", vs, 1'b0);
      end
      chk("sep late", vs, 1'b1);
      cs = 1'b0;
    end
    $display("test separator done");
    complete_run;
  end
endmodule
